/* File: common/lsdf_pkg.sv */
// Purpose: Shared types and constants for the load/store data formatter
// Assumes: 32-bit little-endian data path, byte-addressed memory
// Notes: Size codes are log2 of the access width in bytes
package lsdf_pkg;

  // Access size encoding
  typedef enum logic [1:0]
  {
    LSDF_BYTE = 2'h0,
    LSDF_HALF = 2'h1,
    LSDF_WORD = 2'h2
  } lsdf_size_t;

  localparam int unsigned ADDR_W = 32;
  localparam int unsigned DATA_W = 32;
  localparam logic [3:0] BE_NONE = 4'h0;
  localparam logic [31:0] DATA_RST = 32'h0000_0000;
  localparam logic [31:0] ADDR_RST = 32'h0000_0000;

  // Request from the pipeline stage
  typedef struct packed
  {
    logic valid;
    logic write;
    logic sign;
    lsdf_size_t size;
    logic [31:0] addr;
    logic [31:0] data;
  } lsdf_req_t;

  // Request toward memory
  typedef struct packed
  {
    logic valid;
    logic write;
    logic [3:0] be;
    logic [31:0] addr;
    logic [31:0] data;
  } lsdf_mem_t;

endpackage : lsdf_pkg

/* File: logic/lsdf_lane.sv */
// Purpose: Byte lane steering of store data and right-justify of load data
// Assumes: Address already forced to natural alignment
// Notes: Purely combinational, used by the formatter top
`timescale 1ns/1ps
module lsdf_lane
(
  // Access description
  input wire lsdf_pkg::lsdf_size_t size_i,
  input wire logic [1:0] lane_i,
  input wire logic sign_i,
  // Data in
  input wire logic [31:0] st_data_i,
  input wire logic [31:0] ld_raw_i,
  // Data out
  output logic [31:0] st_lanes_o,
  output logic [3:0] be_o,
  output logic [31:0] ld_data_o
);

  // Shift amount in bits from lane number
  wire [4:0] shamt = {lane_i, 3'h0};
  wire [31:0] ld_shift = ld_raw_i >> shamt;
  wire is_byte = (size_i == lsdf_pkg::LSDF_BYTE);
  wire is_half = (size_i == lsdf_pkg::LSDF_HALF);

  // Store replicated across lanes; strobes pick the live ones
  assign st_lanes_o = is_byte ? {4{st_data_i[7:0]}} :
                      is_half ? {2{st_data_i[15:0]}} : st_data_i;
  assign be_o = is_byte ? (4'h1 << lane_i) :
                is_half ? (lane_i[1] ? 4'hc : 4'h3) : 4'hf;

  // Top bit of the operand is the sign; extend when asked
  wire byte_ext = sign_i & ld_shift[7];
  wire half_ext = sign_i & ld_shift[15];
  assign ld_data_o = is_byte ? {{24{byte_ext}}, ld_shift[7:0]} :
                     is_half ? {{16{half_ext}}, ld_shift[15:0]} : ld_raw_i;

endmodule : lsdf_lane

/* File: logic/lsdf_top.sv */
// Notes on behaviour
// - Multi-byte operands are little-endian, least significant byte at the lowest address.
// - A byte is eight bits at any address, bit 0 least and bit 7 most significant.
// - Signed 8, 16 and 32 bit integers are two's complement.
// - Bit 0 is least significant and the top bit is the sign for every width.
// - A misaligned word has its two low address bits forced to zero, a halfword its low bit.
//
// Purpose: Format load/store operands between the core pipeline and a 32-bit memory port
// Assumes: Memory answers a read with RD_VALID_I some cycles after the request
// Assumes: The pipeline waits for BUSY_O low before it raises a new request
// Notes: One access outstanding; a new request while busy is ignored
// Notes: Misaligned addresses are masked and flagged rather than refused
// Notes: Size code 3 steers like a word but is not masked; keep it off the port
// Notes: The sign request is ignored for words, which already fill the result
// Notes: A store is complete on the edge where memory accepts it
`timescale 1ns/1ps
module lsdf_top
(
  // Clock and reset
  input wire logic CLK_I,
  input wire logic RST_N_I,
  // Pipeline request
  input wire lsdf_pkg::lsdf_req_t REQ_I,
  output logic BUSY_O,
  // Memory port
  output lsdf_pkg::lsdf_mem_t MEM_O,
  input wire logic MEM_READY_I,
  input wire logic RD_VALID_I,
  input wire logic [31:0] RD_DATA_I,
  // Load result
  output logic LD_VALID_O,
  output logic [31:0] LD_DATA_O,
  output logic MISALIGN_O
);

  // Sequencer: idle, waiting for accept, waiting for read data
  typedef enum logic [1:0] {LSDF_IDLE, LSDF_ISSUE, LSDF_WAIT} lsdf_state_t;
  lsdf_state_t state;
  lsdf_state_t next_state;

  // Attributes of the access in flight, needed again when read data returns
  logic sign_q;
  lsdf_pkg::lsdf_size_t size_q;
  logic [1:0] lane_q;

  // Memory side registers, gathered onto MEM_O in one place
  logic mem_valid;
  logic mem_write;
  logic [3:0] mem_be;
  logic [31:0] mem_addr;
  logic [31:0] mem_data;

  // Low address bits masked to the natural boundary
  function automatic logic [31:0] lsdf_align(input lsdf_pkg::lsdf_size_t sz, input logic [31:0] a);
    lsdf_align = (sz == lsdf_pkg::LSDF_WORD) ? {a[31:2], 2'h0} :
                 (sz == lsdf_pkg::LSDF_HALF) ? {a[31:1], 1'h0} : a;
  endfunction : lsdf_align

  // A request is taken only from idle; one while busy is dropped without notice
  wire take = REQ_I.valid && (state == LSDF_IDLE);
  wire [31:0] aligned_addr = lsdf_align(REQ_I.size, REQ_I.addr);
  // Flag only; the access still proceeds on the masked address
  wire misaligned = (aligned_addr != REQ_I.addr);

  // Handshake events, decoded once so the sequencer and the registers agree
  wire issue_done = (state == LSDF_ISSUE) && MEM_READY_I;
  wire load_done = (state == LSDF_WAIT) && RD_VALID_I;

  // Lane controls: live request in the take cycle, the captured copy after it
  lsdf_pkg::lsdf_size_t lane_size;
  wire [1:0] lane_sel = take ? aligned_addr[1:0] : lane_q;
  assign lane_size = lsdf_pkg::lsdf_size_t'(take ? REQ_I.size : size_q);

  // Outputs of the lane steering
  wire [31:0] st_lanes;
  wire [3:0] be;
  wire [31:0] ld_data;

  // Lane steering shared by the store path and the load return path
  lsdf_lane u_lane
  (
    // Access description
    .size_i(lane_size),
    .lane_i(lane_sel),
    .sign_i(sign_q),
    // Data in
    .st_data_i(REQ_I.data),
    .ld_raw_i(RD_DATA_I),
    // Data out
    .st_lanes_o(st_lanes),
    .be_o(be),
    .ld_data_o(ld_data)
  );

  // Sequencing: issue holds until memory accepts, loads then wait for data
  always_comb
  begin
    next_state = state;
    unique case (state)
      LSDF_IDLE:
        if (take)
          next_state = LSDF_ISSUE;
      LSDF_ISSUE:
        if (issue_done)
          next_state = mem_write ? LSDF_IDLE : LSDF_WAIT;
      LSDF_WAIT:
        if (load_done)
          next_state = LSDF_IDLE;
      // Code 3 is never entered; a stray upset falls back to idle instead of hanging
      default:
        next_state = LSDF_IDLE;
    endcase
  end

  // State register, back to idle on reset
  always_ff @(posedge CLK_I or negedge RST_N_I)
  begin
    if (!RST_N_I)
      state <= LSDF_IDLE;
    else
      state <= next_state;
  end

  // Request strobe: raised on take, held through any stall, dropped on the accept edge
  always_ff @(posedge CLK_I or negedge RST_N_I)
  begin
    if (!RST_N_I)
      mem_valid <= 1'b0;
    else if (take)
      mem_valid <= 1'b1;
    else if (issue_done)
      mem_valid <= 1'b0;
  end

  // Enables cleared after accept so an idle port shows no live lane
  always_ff @(posedge CLK_I or negedge RST_N_I)
  begin
    if (!RST_N_I)
      mem_be <= lsdf_pkg::BE_NONE;
    else if (take)
      mem_be <= be;
    else if (issue_done)
      mem_be <= lsdf_pkg::BE_NONE;
  end

  // Direction, address and data only move on a take, so a stalled request stays stable
  always_ff @(posedge CLK_I or negedge RST_N_I)
  begin
    if (!RST_N_I)
    begin
      mem_write <= 1'b0;
      mem_addr <= lsdf_pkg::ADDR_RST;
      mem_data <= lsdf_pkg::DATA_RST;
    end
    else if (take)
    begin
      mem_write <= REQ_I.write;
      mem_addr <= aligned_addr;
      mem_data <= st_lanes;
    end
  end

  // Memory port straight from the registers above
  assign MEM_O = {mem_valid, mem_write, mem_be, mem_addr, mem_data};

  // Attributes for the return path; the request port may change once taken
  always_ff @(posedge CLK_I or negedge RST_N_I)
  begin
    if (!RST_N_I)
    begin
      sign_q <= 1'b0;
      size_q <= lsdf_pkg::LSDF_BYTE;
      lane_q <= 2'h0;
    end
    else if (take)
    begin
      sign_q <= REQ_I.sign;
      size_q <= REQ_I.size;
      lane_q <= aligned_addr[1:0];
    end
  end

  // Misalignment is reported, not refused; the flag holds until the next request
  always_ff @(posedge CLK_I or negedge RST_N_I)
  begin
    if (!RST_N_I)
      MISALIGN_O <= 1'b0;
    else if (take)
      MISALIGN_O <= misaligned;
  end

  // Load strobe, a single-cycle pulse per returned read
  always_ff @(posedge CLK_I or negedge RST_N_I)
  begin
    if (!RST_N_I)
      LD_VALID_O <= 1'b0;
    else
      LD_VALID_O <= load_done;
  end

  // Load result, right-justified and extended; holds until the next load returns
  always_ff @(posedge CLK_I or negedge RST_N_I)
  begin
    if (!RST_N_I)
      LD_DATA_O <= lsdf_pkg::DATA_RST;
    else if (load_done)
      LD_DATA_O <= ld_data;
  end

  // Busy from a flop so the pipeline sees no decode glitch; it equals state not idle,
  // so a request raised while it is low is always taken on the next edge
  always_ff @(posedge CLK_I or negedge RST_N_I)
  begin
    if (!RST_N_I)
      BUSY_O <= 1'b0;
    else
      BUSY_O <= (next_state != LSDF_IDLE);
  end

endmodule : lsdf_top

/* File: verification/lsdf_properties.sv */
// Purpose: Port checks for the formatter top
// Assumes: One access in flight at a time
// Notes: Bound after the module
`timescale 1ns/1ps
module lsdf_properties
(
  // Watched ports
  input wire logic CLK_I,
  input wire logic RST_N_I,
  input wire lsdf_pkg::lsdf_req_t REQ_I,
  input wire logic BUSY_O,
  input wire lsdf_pkg::lsdf_mem_t MEM_O,
  input wire logic MEM_READY_I,
  input wire logic RD_VALID_I,
  input wire logic LD_VALID_O
);
  default clocking @(posedge CLK_I); endclocking
  default disable iff (!RST_N_I);
  // Steps of one access
  sequence s_take;
    REQ_I.valid && !BUSY_O && !MEM_O.valid;
  endsequence
  sequence s_new;
    $rose(MEM_O.valid);
  endsequence
  a_take_issues: assert property (s_take |=> MEM_O.valid) else $error("no memory request");
  a_word_mask: assert property (s_new ##0 $past(REQ_I.size) == lsdf_pkg::LSDF_WORD |->
    MEM_O.addr == {$past(REQ_I.addr[31:2]), 2'h0} && MEM_O.be == 4'hf) else $error("word address or enables");
  a_half_mask: assert property (s_new ##0 $past(REQ_I.size) == lsdf_pkg::LSDF_HALF |->
    MEM_O.addr == {$past(REQ_I.addr[31:1]), 1'h0} && MEM_O.be == ($past(REQ_I.addr[1]) ? 4'hc : 4'h3))
    else $error("half address or enables");
  a_byte_lane: assert property (s_new ##0 $past(REQ_I.size) == lsdf_pkg::LSDF_BYTE |->
    MEM_O.addr == $past(REQ_I.addr) && MEM_O.be == 4'h1 << $past(REQ_I.addr[1:0])) else $error("byte lane");
  a_byte_data: assert property (s_new ##0 MEM_O.write && $past(REQ_I.size) == lsdf_pkg::LSDF_BYTE |->
    MEM_O.data[{$past(REQ_I.addr[1:0]), 3'h0} +: 8] == $past(REQ_I.data[7:0])) else $error("byte store data");
  a_half_data: assert property (s_new ##0 MEM_O.write && $past(REQ_I.size) == lsdf_pkg::LSDF_HALF |->
    MEM_O.data[{$past(REQ_I.addr[1]), 4'h0} +: 16] == $past(REQ_I.data[15:0])) else $error("half store data");
  a_req_holds: assert property (MEM_O.valid && !MEM_READY_I |=> MEM_O.valid && $stable(MEM_O))
    else $error("request dropped");
  a_load_answer: assert property (RD_VALID_I && BUSY_O && !MEM_O.valid |=> LD_VALID_O)
    else $error("no load result");
endmodule : lsdf_properties

bind lsdf_top lsdf_properties u_props (.CLK_I(CLK_I), .RST_N_I(RST_N_I), .REQ_I(REQ_I), .BUSY_O(BUSY_O),
  .MEM_O(MEM_O), .MEM_READY_I(MEM_READY_I), .RD_VALID_I(RD_VALID_I), .LD_VALID_O(LD_VALID_O));

/* File: verification/lsdf_mem_model.sv */
// Purpose: Little-endian memory behind the formatter
// Assumes: Sixteen words, low address bits only
// Notes: Stalls while slow_i is high
`timescale 1ns/1ps
module lsdf_mem_model
(
  // Clock and reset
  input wire logic clk_i,
  input wire logic rst_n_i,
  // Memory port
  input wire lsdf_pkg::lsdf_mem_t mem_i,
  input wire logic slow_i,
  output logic ready_o,
  output logic rd_valid_o,
  output logic [31:0] rd_data_o
);
  logic [31:0] ram [0:15];
  assign ready_o = mem_i.valid && !slow_i;
  // Read data changes every idle cycle so stale data never matches
  always_ff @(posedge clk_i or negedge rst_n_i)
    if (!rst_n_i)
    begin
      rd_valid_o <= 1'b0;
      rd_data_o <= 32'h0;
    end
    else
    begin
      rd_valid_o <= ready_o && !mem_i.write;
      rd_data_o <= (ready_o && !mem_i.write) ? ram[mem_i.addr[5:2]] : ~rd_data_o;
      for (int b = 0; b < 4; b++)
        if (ready_o && mem_i.write && mem_i.be[b])
          ram[mem_i.addr[5:2]][8*b +: 8] <= mem_i.data[8*b +: 8];
    end
endmodule : lsdf_mem_model

/* File: verification/load_store_data_formatter_bench.sv */
// Purpose: Self-checking bench for the formatter
// Assumes: Memory model answers one cycle after accept
// Notes: Odd rows stall the memory two cycles
`timescale 1ns/1ps
module load_store_data_formatter_bench;
  typedef struct packed {logic w; logic s; logic [1:0] z; logic [31:0] a; logic [31:0] d;} lsdf_row_t;
  logic clk, rst_n, busy, ready, rd_valid, ld_valid, misalign, slow;
  logic [31:0] rd_data, ld_data;
  lsdf_pkg::lsdf_req_t req;
  lsdf_pkg::lsdf_mem_t mem;
  int fails = 0;
  int checked = 0;
  int cyc = 0;
  // Writes carry data, reads carry the expected result
  lsdf_row_t rows [13] = '{'{1, 0, 2, 0, 32'h8765f4a1}, '{0, 0, 0, 0, 32'ha1}, '{0, 1, 0, 1, 32'hfffffff4},
    '{0, 0, 0, 3, 32'h87}, '{0, 1, 0, 3, 32'hffffff87}, '{0, 1, 1, 0, 32'hfffff4a1}, '{0, 1, 1, 2, 32'hffff8765},
    '{0, 0, 1, 3, 32'h8765}, '{0, 0, 2, 3, 32'h8765f4a1}, '{1, 0, 0, 2, 32'h5a}, '{1, 0, 1, 1, 32'h1234},
    '{0, 0, 2, 0, 32'h875a1234}, '{0, 1, 0, 1, 32'h12}};
  lsdf_top dut (.CLK_I(clk), .RST_N_I(rst_n), .REQ_I(req), .BUSY_O(busy), .MEM_O(mem), .MEM_READY_I(ready),
    .RD_VALID_I(rd_valid), .RD_DATA_I(rd_data), .LD_VALID_O(ld_valid), .LD_DATA_O(ld_data), .MISALIGN_O(misalign));
  lsdf_mem_model u_mem (.clk_i(clk), .rst_n_i(rst_n), .mem_i(mem), .slow_i(slow), .ready_o(ready),
    .rd_valid_o(rd_valid), .rd_data_o(rd_data));
  task automatic chk(input string n, input logic [31:0] e, input logic [31:0] s);
    checked++;
    if (s !== e)
    begin
      fails++;
      $display("Error %s expected %h seen %h", n, e, s);
    end
  endtask : chk
  task automatic final_report;
    $display("checked %0d fails %0d", checked, fails);
    if (fails == 0 && checked > 0)
      $display("verification passed");
    else
      $display("verification failed");
    $finish;
  endtask : final_report
  // Clock and hang guard
  initial
  begin
    clk = 1'b0;
    forever #12.5 clk = ~clk;
  end
  always @(posedge clk)
  begin
    cyc <= cyc + 1;
    if (cyc == 2000)
    begin
      fails++;
      final_report();
    end
  end
  initial
  begin
    rst_n = 1'b0;
    req = '0;
    slow = 1'b0;
    repeat (2) @(negedge clk);
    rst_n = 1'b1;
    foreach (rows[i])
    begin
      req = {1'b1, rows[i].w, rows[i].s, rows[i].z, rows[i].a, rows[i].d};
      slow = i[0];
      @(negedge clk);
      req.valid = 1'b0;
      for (int k = 0; k < 20 && (rows[i].w ? busy : !ld_valid); k++)
      begin
        if (k == 2)
          slow = 1'b0;
        @(negedge clk);
      end
      if (!rows[i].w)
        chk("load data", rows[i].d, ld_data);
      chk("done", 32'h0, {31'h0, rows[i].w ? busy : !ld_valid});
      chk("misalign", {31'h0, (rows[i].z == 1 && rows[i].a[0]) ||
        (rows[i].z == 2 && rows[i].a[1:0] != 0)}, {31'h0, misalign});
    end
    // Reset in mid access clears busy, the request strobe, both load outputs and the flag
    req = {1'b1, 1'b0, 1'b0, lsdf_pkg::LSDF_WORD, 32'h4, 32'h0};
    @(negedge clk);
    rst_n = 1'b0;
    req = '0;
    #1;
    chk("reset", 32'h0, ld_data | {busy, mem.valid, ld_valid, misalign, 28'h0});
    // Release and a fresh signed halfword load must work at once
    @(negedge clk);
    rst_n = 1'b1;
    req = {1'b1, 1'b0, 1'b1, lsdf_pkg::LSDF_HALF, 32'h2, 32'h0};
    @(negedge clk);
    req.valid = 1'b0;
    repeat (2) @(negedge clk);
    chk("load after reset", 32'hffff875a, ld_data);
    final_report();
  end
endmodule : load_store_data_formatter_bench
